// [bench/tb_temp_capability_readout_regs.sv]
// self-checking bench for the temperature readout block
`timescale 1ns/100ps
module tb_temp_capability_readout_regs;
    logic clk_in = 1'b0, rst_n_in = 1'b0, reg_rd_in = 1'b0, reg_wr_in = 1'b0;
    logic [5:0] reg_addr_in = 6'h00;
    logic [15:0] reg_wr_data_in = 16'h0000, reg_rd_data_out, e_word = 16'h0000, e_rd = 16'h0000;
    logic reg_rd_valid_out, conv_start_out, conv_sensor_out, conv_done_in, conv_fault_in;
    logic temp_result_ready_flag_out, temp_overrun_flag_out, attention_request_out;
    logic [9:0] conv_temp_in, m_temp = 10'h000;
    logic [3:0] m_lag = 4'h4;
    logic [2:0] e_ctrl = 3'h0;
    logic m_fault = 1'b0, e_rdy = 1'b0, e_ovr = 1'b0, e_att = 1'b0, e_last = 1'b1, go = 1'b0, f;
    logic rd9;
    logic [9:0] tbl [4] = '{10'h1ff, 10'h200, 10'h3ff, 10'h001};
    integer n_errors = 0, total_checks = 0, seed = 32'h7b8b36c6, cyc = 0, i;
    always #10 clk_in = ~clk_in;
    tcr_top u_dut(.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_wr_data_in(reg_wr_data_in),
        .reg_rd_data_out(reg_rd_data_out), .reg_rd_valid_out(reg_rd_valid_out),
        .conv_start_out(conv_start_out), .conv_sensor_out(conv_sensor_out),
        .conv_done_in(conv_done_in), .conv_temp_in(conv_temp_in), .conv_fault_in(conv_fault_in),
        .temp_result_ready_flag_out(temp_result_ready_flag_out),
        .temp_overrun_flag_out(temp_overrun_flag_out),
        .attention_request_out(attention_request_out));
    tcr_conv_model u_conv(.clk_in(clk_in), .start_in(conv_start_out), .temp_in(m_temp),
        .fault_in(m_fault), .lag_in(m_lag), .done_out(conv_done_in), .temp_out(conv_temp_in),
        .fault_out(conv_fault_in));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wr_data_in = d;
        reg_wr_in = 1'b1;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        reg_wr_data_in = ~d;
        if (a == 6'h0a) e_ctrl = d[2:0];
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        chk({15'h0, reg_rd_valid_out}, 16'h0001);
        chk(reg_rd_data_out, a == 6'h09 ? e_rd : e);
    endtask
    // while a sensor is enabled, enables change only while a conversion waits, so the next pick is unambiguous
    task automatic setc(input logic [15:0] d);
        if (e_ctrl[2:1] != 2'b00) begin
            do begin
                @(posedge clk_in);
            end while (conv_start_out !== 1'b1);
        end
        wr(6'h0a, d);
    endtask
    // no local limit: a converter that never answers runs into the cycle ceiling
    task automatic wstore(input integer n);
        repeat (n) begin
            do begin
                @(posedge clk_in);
            end while (conv_done_in !== 1'b1);
        end
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 2000) begin
            n_errors++;
            finish_test();
        end
    end
    always @(posedge clk_in) begin
        rd9 = reg_rd_in && reg_addr_in == 6'h09;
        if (rd9) e_rd = e_word;
        e_att = conv_done_in && e_ctrl[0];
        if (conv_start_out === 1'b1) begin
            e_last = (e_ctrl[2:1] == 2'b11) ? ~e_last : e_ctrl[2];
            chk({15'h0, conv_sensor_out}, {15'h0, e_last});
        end
        if (conv_done_in === 1'b1) begin
            f = conv_fault_in & e_last;
            e_word = {f ? 10'h200 : conv_temp_in, 3'h0, e_last, f, 1'b0};
            // a read in the same cycle consumed the old result and clears overrun
            e_ovr = (e_ovr | e_rdy) & !rd9;
            e_rdy = 1'b1;
        end else if (rd9) begin
            e_rdy = 1'b0;
            e_ovr = 1'b0;
        end
    end
    always @(negedge clk_in)
        if (go) chk({13'h0, attention_request_out, temp_overrun_flag_out,
            temp_result_ready_flag_out}, {13'h0, e_att, e_ovr, e_rdy});
    initial begin
        repeat (6) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        go = 1'b1;
        rd(6'h08, 16'h0349);
        wr(6'h08, $random(seed));
        rd(6'h08, 16'h0349);
        rd(6'h3f, 16'h0000);
        $display("test 1 done");
        m_fault = 1'b1;
        m_temp = $random(seed);
        setc(16'h0003);
        wstore(3);
        rd(6'h09, 16'h0000);
        rd(6'h0a, 16'h0003);
        $display("test 2 done");
        setc(16'h0007);
        for (i = 0; i < 8; i++) begin
            m_temp = (i < 4) ? tbl[i] : $random(seed);
            m_fault = i[1];
            m_lag = $random(seed) & 4'h7;
            wstore(1);
            rd(6'h09, 16'h0000);
        end
        $display("test 3 done");
        m_lag = 4'h4;
        setc(16'h0005);
        wstore(1);
        rd(6'h09, 16'h0000);
        setc(16'h0004);
        wstore(2);
        rd(6'h09, 16'h0000);
        setc(16'h0000);
        wstore(1);
        rd(6'h09, 16'h0000);
        repeat (20) @(negedge clk_in);
        $display("test 4 done");
        finish_test();
    end
endmodule

// [bench/tcr_checker.sv]
// port assertions for the temperature readout block
`timescale 1ns/100ps
module tcr_checker(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wr_data_in,
    input wire logic [15:0] reg_rd_data_out,
    input wire logic reg_rd_valid_out,
    input wire logic conv_start_out,
    input wire logic conv_sensor_out,
    input wire logic conv_done_in,
    input wire logic [9:0] conv_temp_in,
    input wire logic conv_fault_in,
    input wire logic temp_result_ready_flag_out,
    input wire logic temp_overrun_flag_out,
    input wire logic attention_request_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd(a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    sequence s_word;
        s_rd(6'h09) ##1 reg_rd_valid_out;
    endsequence
    caps_value_a: assert property (
        s_rd(6'h08) |=> reg_rd_data_out == 16'h0349)
        else $error("capabilities word wrong");
    rsvd_zero_a: assert property (
        s_word |-> reg_rd_data_out[5:3] == 3'h0 && !reg_rd_data_out[0])
        else $error("reserved readout bits set");
    local_flag_a: assert property (
        s_word ##0 !reg_rd_data_out[2] |-> !reg_rd_data_out[1])
        else $error("fault flag on local result");
    fault_code_a: assert property (
        s_word ##0 reg_rd_data_out[1] |-> reg_rd_data_out[15:6] == 10'h200)
        else $error("fault code not loaded");
    read_clear_a: assert property (
        s_rd(6'h09) ##0 !conv_done_in |=>
            !temp_result_ready_flag_out && !temp_overrun_flag_out)
        else $error("flags not cleared by read");
    ready_set_a: assert property (
        $rose(temp_result_ready_flag_out) |-> $past(conv_done_in))
        else $error("ready without a result");
    overrun_set_a: assert property (
        $rose(temp_overrun_flag_out) |->
            $past(temp_result_ready_flag_out && conv_done_in))
        else $error("overrun without unread result");
    attn_pulse_a: assert property (
        attention_request_out |-> temp_result_ready_flag_out && $past(conv_done_in))
        else $error("attention without a result");
    start_gap_a: assert property (
        conv_start_out |=> !conv_start_out [*2])
        else $error("starts too close");
    sensor_hold_a: assert property (
        $past(conv_start_out) |-> $stable(conv_sensor_out))
        else $error("sensor changed after start");
endmodule
bind tcr_top tcr_checker u_chk(.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_wr_data_in(reg_wr_data_in),
    .reg_rd_data_out(reg_rd_data_out), .reg_rd_valid_out(reg_rd_valid_out),
    .conv_start_out(conv_start_out), .conv_sensor_out(conv_sensor_out),
    .conv_done_in(conv_done_in), .conv_temp_in(conv_temp_in), .conv_fault_in(conv_fault_in),
    .temp_result_ready_flag_out(temp_result_ready_flag_out),
    .temp_overrun_flag_out(temp_overrun_flag_out), .attention_request_out(attention_request_out));

// [bench/tcr_conv_model.sv]
// converter model answering start pulses after a set lag
`timescale 1ns/100ps
module tcr_conv_model(
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [9:0] temp_in,
    input wire logic fault_in,
    input wire logic [3:0] lag_in,
    output logic done_out,
    output logic [9:0] temp_out,
    output logic fault_out
);
    initial begin
        done_out = 1'b0;
        temp_out = 10'h000;
        fault_out = 1'b0;
        forever begin
            @(posedge clk_in);
            if (start_in === 1'b1) begin
                repeat (lag_in) @(posedge clk_in);
                @(negedge clk_in);
                done_out = 1'b1;
                temp_out = temp_in;
                fault_out = fault_in;
                @(negedge clk_in);
                done_out = 1'b0;
                // stale data scrambled so a late sample shows
                temp_out = ~temp_in;
                fault_out = ~fault_in;
            end
        end
    end
endmodule

// [logic/tcr_defs.svh]
// constants of the temperature capability and readout registers
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

`define TCR_ADDR_W 6
`define TCR_DATA_W 16
`define TCR_TEMP_W 10

// register offsets
`define TCR_OFS_CAPS 6'h08
`define TCR_OFS_READOUT 6'h09
`define TCR_OFS_CTRL 6'h0a

// capabilities word fields
`define TCR_CAP_RESOLUTION 3'h1
`define TCR_CAP_NUM_BITS 3'h1
`define TCR_CAP_SIGNED 1'b1
`define TCR_CAP_RESULT_WORD_SIZE 1'b0
`define TCR_CAP_LOCAL_SENSOR_PRESENT 1'b1
`define TCR_CAP_NUM_REMOTES 3'h1
`define TCR_CAP_RESERVED 4'h0

// readout word field positions
`define TCR_RO_TEMP_LSB 6
`define TCR_RO_SENSOR_BIT 2
`define TCR_RO_FAULT_BIT 1

// control register bit positions
`define TCR_CTRL_ATE_BIT 0
`define TCR_CTRL_EN0_BIT 1
`define TCR_CTRL_EN1_BIT 2

// temperature code loaded on a diode fault (-256 degrees)
`define TCR_FAULT_CODE 10'h200

// reset values
`define TCR_RST_WORD 16'h0000
`define TCR_RST_CTRL 1'b0
`define TCR_RST_FLAG 1'b0

`endif

// [logic/tcr_pkg.sv]
// types shared by the temperature readout block
package tcr_pkg;

    typedef enum logic [2:0] {
        TCR_SCAN_IDLE = 3'b001,
        TCR_SCAN_START = 3'b010,
        TCR_SCAN_WAIT = 3'b100
    } tcr_scan_state_e;

    typedef struct packed {
        tcr_scan_state_e state;
        logic sensor_index;
        logic next_index;
    } tcr_scan_s;

    typedef struct packed {
        logic attention_request_enable;
        logic local_sensor_enable;
        logic remote_sensor_enable;
        logic [15:0] readout;
        logic temp_result_ready_flag;
        logic temp_overrun_flag;
        logic attention;
        logic [15:0] rd_data;
        logic rd_valid;
    } tcr_regs_s;

endpackage

// [logic/tcr_scan.sv]
// round-robin sensor scanner driving the converter
`timescale 1ns/100ps
`include "tcr_defs.svh"

module tcr_scan
    import tcr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // sensor enables
    input wire logic local_sensor_enable_in,
    input wire logic remote_sensor_enable_in,
    // converter handshake
    input wire logic conv_done_in,
    output logic conv_start_out,
    output logic conv_sensor_out,
    // result event
    output logic result_store_out,
    output logic result_sensor_out
);

    tcr_scan_s cur;
    tcr_scan_s nxt;

    // first enabled sensor at or after the given index, wrapping
    function automatic logic pick_sensor(input logic from_idx, input logic en0,
                                         input logic en1);
        if (from_idx == 1'b0) begin
            pick_sensor = en0 ? 1'b0 : 1'b1;
        end else begin
            pick_sensor = en1 ? 1'b1 : 1'b0;
        end
    endfunction

    always_comb begin
        nxt = cur;
        unique case (cur.state)
            TCR_SCAN_IDLE: begin
                if (local_sensor_enable_in || remote_sensor_enable_in) begin
                    nxt.sensor_index = pick_sensor(cur.next_index,
                        local_sensor_enable_in, remote_sensor_enable_in);
                    nxt.state = TCR_SCAN_START;
                end
            end
            TCR_SCAN_START: begin
                nxt.state = TCR_SCAN_WAIT;
            end
            TCR_SCAN_WAIT: begin
                if (conv_done_in) begin
                    // ascending order, sensor 1 wraps to sensor 0
                    nxt.next_index = ~cur.sensor_index;
                    nxt.state = TCR_SCAN_IDLE;
                end
            end
            default: begin
                nxt.state = TCR_SCAN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur <= '{state: TCR_SCAN_IDLE, sensor_index: 1'b0, next_index: 1'b0};
        end else begin
            cur <= nxt;
        end
    end

    assign conv_start_out = (cur.state == TCR_SCAN_START);
    assign conv_sensor_out = cur.sensor_index;
    assign result_store_out = (cur.state == TCR_SCAN_WAIT) && conv_done_in;
    assign result_sensor_out = cur.sensor_index;

endmodule

// [logic/tcr_top.sv]
// temperature capability and readout register function
//
// Functional notes
// - capabilities word is a fixed constant, writes never alter it
// - capabilities bits 2:0 read 001, half degree per step
// - capabilities bits 5:3 read 001, ten significant bits
// - capabilities bit 6 reads one, signed two's complement result
// - capabilities bit 7 reads zero, sixteen-bit readout word
// - capabilities bit 8 reads one, local sensor present
// - capabilities bits 11:9 read one remote sensor
// - capabilities bits 15:12 read zero
// - readout bits 0 and 5:3 zero; bit 1 zero for local results
// - readout bit 1 flags a remote measurement error
// - diode fault loads the -256 degree code into the temperature field
// - readout bit 2 gives sensor number, 0 local, 1 remote
// - readout bits 15:6 hold the left-justified ten-bit temperature
// - temperature code is two's complement, +255.5 to -256 degrees
// - new result sets ready flag; readout read clears ready and overrun
// - unread result is overwritten and overrun flag set
// - enabled sensors scanned ascending round-robin, disabled ones skipped
// - attention request on new result only when enabled
`timescale 1ns/100ps
`include "tcr_defs.svh"

module tcr_top
    import tcr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register access from the serial bus engine
    input wire logic [5:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wr_data_in,
    output logic [15:0] reg_rd_data_out,
    output logic reg_rd_valid_out,
    // converter interface
    output logic conv_start_out,
    output logic conv_sensor_out,
    input wire logic conv_done_in,
    input wire logic [9:0] conv_temp_in,
    input wire logic conv_fault_in,
    // status toward the device status logic
    output logic temp_result_ready_flag_out,
    output logic temp_overrun_flag_out,
    output logic attention_request_out
);

    // reset release synchroniser
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // fixed capabilities word, bits 15 down to 0
    localparam logic [15:0] CAPS_WORD = {
        `TCR_CAP_RESERVED,
        `TCR_CAP_NUM_REMOTES,
        `TCR_CAP_LOCAL_SENSOR_PRESENT,
        `TCR_CAP_RESULT_WORD_SIZE,
        `TCR_CAP_SIGNED,
        `TCR_CAP_NUM_BITS,
        `TCR_CAP_RESOLUTION
    };

    tcr_regs_s cur;
    tcr_regs_s nxt;

    logic result_store;
    logic result_sensor;

    tcr_scan u_scan (
        .clk_in(clk_in),
        .rst_n_in(rst_sync_n),
        .local_sensor_enable_in(cur.local_sensor_enable),
        .remote_sensor_enable_in(cur.remote_sensor_enable),
        .conv_done_in(conv_done_in),
        .conv_start_out(conv_start_out),
        .conv_sensor_out(conv_sensor_out),
        .result_store_out(result_store),
        .result_sensor_out(result_sensor)
    );

    // pack one conversion into the readout layout
    function automatic logic [15:0] build_readout(input logic sensor,
                                                  input logic [9:0] temp,
                                                  input logic fault);
        logic remote_fault;
        logic [9:0] code;
        logic [15:0] word;
        remote_fault = sensor && fault;
        // a broken diode gives no usable reading, report the floor code
        code = remote_fault ? `TCR_FAULT_CODE : temp;
        word = 16'h0000;
        word[15:`TCR_RO_TEMP_LSB] = code;
        word[`TCR_RO_SENSOR_BIT] = sensor;
        word[`TCR_RO_FAULT_BIT] = remote_fault;
        build_readout = word;
    endfunction

    // register read mux; unmapped addresses read zero
    function automatic logic [15:0] read_mux(input logic [5:0] addr,
                                             input tcr_regs_s r);
        logic [15:0] ctrl_word;
        ctrl_word = 16'h0000;
        ctrl_word[`TCR_CTRL_ATE_BIT] = r.attention_request_enable;
        ctrl_word[`TCR_CTRL_EN0_BIT] = r.local_sensor_enable;
        ctrl_word[`TCR_CTRL_EN1_BIT] = r.remote_sensor_enable;
        case (addr)
            `TCR_OFS_CAPS: read_mux = CAPS_WORD;
            `TCR_OFS_READOUT: read_mux = r.readout;
            `TCR_OFS_CTRL: read_mux = ctrl_word;
            default: read_mux = 16'h0000;
        endcase
    endfunction

    logic readout_read;
    logic ctrl_write;

    assign readout_read = reg_rd_in && (reg_addr_in == `TCR_OFS_READOUT);
    // only the control word takes writes; capabilities and readout ignore them
    assign ctrl_write = reg_wr_in && (reg_addr_in == `TCR_OFS_CTRL);

    always_comb begin
        nxt = cur;
        nxt.rd_valid = reg_rd_in;
        nxt.attention = 1'b0;

        if (reg_rd_in) begin
            // captured before this edge's store, so the word is always whole
            nxt.rd_data = read_mux(reg_addr_in, cur);
        end

        if (ctrl_write) begin
            nxt.attention_request_enable = reg_wr_data_in[`TCR_CTRL_ATE_BIT];
            nxt.local_sensor_enable = reg_wr_data_in[`TCR_CTRL_EN0_BIT];
            nxt.remote_sensor_enable = reg_wr_data_in[`TCR_CTRL_EN1_BIT];
        end

        if (readout_read) begin
            nxt.temp_result_ready_flag = 1'b0;
            nxt.temp_overrun_flag = 1'b0;
        end

        if (result_store) begin
            // whole word replaced in one edge
            nxt.readout = build_readout(result_sensor, conv_temp_in,
                                        conv_fault_in);
            // set wins over a read in the same cycle
            nxt.temp_result_ready_flag = 1'b1;
            // a read in this very cycle consumed the old result in time
            if (cur.temp_result_ready_flag && !readout_read) begin
                nxt.temp_overrun_flag = 1'b1;
            end
            nxt.attention = cur.attention_request_enable;
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cur <= '{
                attention_request_enable: `TCR_RST_CTRL,
                local_sensor_enable: `TCR_RST_CTRL,
                remote_sensor_enable: `TCR_RST_CTRL,
                readout: `TCR_RST_WORD,
                temp_result_ready_flag: `TCR_RST_FLAG,
                temp_overrun_flag: `TCR_RST_FLAG,
                attention: 1'b0,
                rd_data: `TCR_RST_WORD,
                rd_valid: 1'b0
            };
        end else begin
            cur <= nxt;
        end
    end

    assign reg_rd_data_out = cur.rd_data;
    assign reg_rd_valid_out = cur.rd_valid;
    assign temp_result_ready_flag_out = cur.temp_result_ready_flag;
    assign temp_overrun_flag_out = cur.temp_overrun_flag;
    assign attention_request_out = cur.attention;

endmodule
